//--- rtl/tfw_wavegen.v
// Timer wave generator: counter, compare units, output pins and Avalon-MM registers.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`include "tfw_wavegen_regs.vh"

module tfw_wavegen (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Prescaled timer tick, one cycle wide
	input wire timer_tick,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// General port values used when no waveform drives the pin
	input wire port_out_a,
	input wire port_out_b,
	// Waveform pins
	output reg wave_pin_a_out,
	output reg wave_pin_a_oe_n,
	output reg wave_pin_b_out,
	output reg wave_pin_b_oe_n,
	// Event flags
	output reg overflow_flag,
	output reg compare_a_flag,
	output reg compare_b_flag,
	output reg capture_flag
);

	// Overview of the block.
	// The counter, the compare matches and the flag sets all happen only at an edge where
	// timer_tick is high, so the prescaler alone sets the waveform rate.
	// The mode field picks one of three counting styles: clear on a top match,
	// single-slope fast PWM or dual-slope phase-correct PWM.
	// In the PWM modes the compare registers are double buffered and load at top.
	// In the other modes a compare write reaches the comparator at once, so
	// software that lowers top below the count must accept a full wrap first.
	// Software sees the buffer through the bus, never the active compare value.
	// Every output leaves through a flip-flop; waveform pin values and flags change at
	// the same edge as the internal state that they follow, enables one edge after the ctrl bits.

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [9:0] ctrl;
	reg [15:0] counter_value;
	reg count_up;
	reg [15:0] cmpa_buf;
	reg [15:0] cmpa_act;
	reg [15:0] cmpb_buf;
	reg [15:0] cmpb_act;
	reg [15:0] capture_top_value;
	reg wave_a;
	reg wave_b;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire [3:0] waveform_mode_select = ctrl[`TFW_CTRL_MODE_LSB +: 4];
	wire [1:0] output_a_action = ctrl[`TFW_CTRL_ACTA_LSB +: 2];
	wire [1:0] output_b_action = ctrl[`TFW_CTRL_ACTB_LSB +: 2];
	reg is_fast;
	reg is_pc;
	reg top_from_a;
	reg top_from_cap;
	reg [15:0] top;
	reg [15:0] fix_mask;

	// Top value and mode class; capture-top is read live, compare A as top is the active value, buffered in PWM modes.
	always @* begin
		is_fast = 1'b0;
		is_pc = 1'b0;
		top_from_a = 1'b0;
		top_from_cap = 1'b0;
		top = `TFW_MAX;
		fix_mask = `TFW_MAX;
		case (waveform_mode_select)
			`TFW_MODE_CLR_A: begin
				top_from_a = 1'b1;
				top = cmpa_act;
			end
			`TFW_MODE_CLR_I: begin
				top_from_cap = 1'b1;
				top = capture_top_value;
			end
			`TFW_MODE_FP8, `TFW_MODE_PC8: begin
				is_fast = (waveform_mode_select == `TFW_MODE_FP8);
				is_pc = (waveform_mode_select == `TFW_MODE_PC8);
				top = `TFW_TOP8;
				fix_mask = `TFW_TOP8;
			end
			`TFW_MODE_FP9, `TFW_MODE_PC9: begin
				is_fast = (waveform_mode_select == `TFW_MODE_FP9);
				is_pc = (waveform_mode_select == `TFW_MODE_PC9);
				top = `TFW_TOP9;
				fix_mask = `TFW_TOP9;
			end
			`TFW_MODE_FP10, `TFW_MODE_PC10: begin
				is_fast = (waveform_mode_select == `TFW_MODE_FP10);
				is_pc = (waveform_mode_select == `TFW_MODE_PC10);
				top = `TFW_TOP10;
				fix_mask = `TFW_TOP10;
			end
			`TFW_MODE_FP_I, `TFW_MODE_PC_I: begin
				is_fast = (waveform_mode_select == `TFW_MODE_FP_I);
				is_pc = (waveform_mode_select == `TFW_MODE_PC_I);
				top_from_cap = 1'b1;
				top = capture_top_value;
			end
			`TFW_MODE_FP_A, `TFW_MODE_PC_A: begin
				is_fast = (waveform_mode_select == `TFW_MODE_FP_A);
				is_pc = (waveform_mode_select == `TFW_MODE_PC_A);
				top_from_a = 1'b1;
				top = cmpa_act;
			end
			default: begin
				top = `TFW_MAX;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Compare and top detection
	// ----------------------------------------------------------------
	wire pwm = is_fast | is_pc;
	wire at_top = (counter_value == top);
	wire at_max = (counter_value == `TFW_MAX);
	wire at_bottom = (counter_value == `TFW_BOTTOM);
	wire match_a = timer_tick & (counter_value == cmpa_act);
	wire match_b = timer_tick & (counter_value == cmpb_act);
	wire fast_wrap = timer_tick & is_fast & at_top;
	wire pc_turn = timer_tick & is_pc & count_up & at_top;
	wire pc_bottom = timer_tick & is_pc & ~count_up & at_bottom;
	wire load_cmp = fast_wrap | pc_turn;
	// Channel A may toggle outside the non-PWM modes only when it defines top.
	wire tog_ok_a = ~pwm | top_from_a;
	wire tog_ok_b = ~pwm;

	// The same function serves both channels, so their rules cannot drift apart.
	// Action 0 never touches the state, which lets software preset the state
	// in one mode and carry it unchanged into another.
	// Action 1 toggles only where the caller allows it through tog_ok.
	// Next waveform state of one channel for one tick.
	function wave_next;
		input cur;
		input [1:0] act;
		input match;
		input wrap;
		input tog_ok;
		input fast;
		input pc;
		input up;
		begin
			wave_next = cur;
			if (act == 2'h0) begin
				wave_next = cur;
			end else if (act == 2'h1) begin
				if (match && tog_ok)
					wave_next = ~cur;
			end else if (fast) begin
				// Action 2 sets on a match and clears at the wrap; action 3 is the reverse.
				// Wrap wins over match, so compare equal to top holds a level.
				if (wrap)
					wave_next = (act == 2'h3);
				else if (match)
					wave_next = (act == 2'h2);
			end else if (pc) begin
				if (match)
					wave_next = (act == 2'h2) ? ~up : up;
			end else begin
				if (match)
					wave_next = (act == 2'h3);
			end
		end
	endfunction

	wire next_wave_a = wave_next(wave_a, output_a_action, match_a, fast_wrap, tog_ok_a,
		is_fast, is_pc, count_up);
	wire next_wave_b = wave_next(wave_b, output_b_action, match_b, fast_wrap, tog_ok_b,
		is_fast, is_pc, count_up);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_req = avs_read | avs_write;
	wire do_write = avs_write & ~avs_waitrequest;
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire wr_ctrl = do_write & (avs_address == `TFW_OFS_CTRL);
	wire wr_cmpa = do_write & (avs_address == `TFW_OFS_CMPA);
	wire wr_cmpb = do_write & (avs_address == `TFW_OFS_CMPB);
	wire wr_cap = do_write & (avs_address == `TFW_OFS_CAPTOP);
	wire wr_flags = do_write & (avs_address == `TFW_OFS_FLAGS);

	// Byte-lane merge of write data into an old value.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wdata;
		input [31:0] mask;
		begin
			merge16 = (old & ~mask[15:0]) | (wdata[15:0] & mask[15:0]);
		end
	endfunction

	wire [15:0] new_cmpa = merge16(cmpa_buf, avs_writedata, be_mask) & fix_mask;
	wire [15:0] new_cmpb = merge16(cmpb_buf, avs_writedata, be_mask) & fix_mask;
	wire [15:0] new_cap = merge16(capture_top_value, avs_writedata, be_mask);
	wire [3:0] flag_clr = wr_flags ? (avs_writedata[3:0] & {4{avs_byteenable[0]}}) : 4'h0;

	// Read mux; unmapped offsets read zero.
	reg [31:0] next_readdata;
	always @* begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`TFW_OFS_CTRL: next_readdata = {22'h00_0000, ctrl};
			`TFW_OFS_COUNT: next_readdata = {16'h0000, counter_value};
			`TFW_OFS_CMPA: next_readdata = {16'h0000, cmpa_buf};
			`TFW_OFS_CMPB: next_readdata = {16'h0000, cmpb_buf};
			`TFW_OFS_CAPTOP: next_readdata = {16'h0000, capture_top_value};
			`TFW_OFS_FLAGS: next_readdata = {28'h000_0000, capture_flag, compare_b_flag,
				compare_a_flag, overflow_flag};
			`TFW_OFS_STATUS: next_readdata = {29'h0000_0000, count_up, wave_b, wave_a};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus handshake: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	// The wait cycle gives the read mux a full clock before the data is shown.
	// Read data is latched in that wait cycle and holds until the next read or write.
	// Writes take effect only at the edge where waitrequest is low, so a
	// master that holds its request longer writes again at every second edge.
	always @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			if (bus_req && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= next_readdata;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and compare registers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= `TFW_CTRL_RST;
			cmpa_buf <= `TFW_CMP_RST;
			cmpa_act <= `TFW_CMP_RST;
			cmpb_buf <= `TFW_CMP_RST;
			cmpb_act <= `TFW_CMP_RST;
			capture_top_value <= `TFW_CMP_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= (ctrl & ~be_mask[9:0]) | (avs_writedata[9:0] & be_mask[9:0]);
			if (wr_cap)
				capture_top_value <= new_cap;
			if (wr_cmpa)
				cmpa_buf <= new_cmpa;
			if (wr_cmpb)
				cmpb_buf <= new_cmpb;
			// PWM modes load the active compare at top; other modes write through.
			if (pwm) begin
				if (load_cmp) begin
					cmpa_act <= cmpa_buf;
					cmpb_act <= cmpb_buf;
				end
			end else begin
				if (wr_cmpa)
					cmpa_act <= new_cmpa;
				if (wr_cmpb)
					cmpb_act <= new_cmpb;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// The counter only moves on a tick, so a stopped prescaler freezes it.
	// Single-slope modes clear at top; a top that is already passed is missed,
	// and the count then runs through 0xFFFF before it can match again.
	// Dual-slope modes turn at top and at bottom, each end held for one tick.
	// count_up is forced high at each tick in single-slope modes, so that a later switch
	// to a dual-slope mode after at least one such tick starts on the rising slope.
	always @(posedge clk) begin
		if (sys_rst) begin
			counter_value <= `TFW_CNT_RST;
			count_up <= 1'b1;
		end else if (timer_tick) begin
			if (is_pc) begin
				if (count_up && at_top) begin
					count_up <= 1'b0;
					counter_value <= counter_value - 16'h0001;
				end else if (!count_up && at_bottom) begin
					count_up <= 1'b1;
					counter_value <= counter_value + 16'h0001;
				end else if (count_up) begin
					counter_value <= counter_value + 16'h0001;
				end else begin
					counter_value <= counter_value - 16'h0001;
				end
			end else begin
				count_up <= 1'b1;
				// A top below the count is missed and the count wraps past 0xFFFF.
				if (at_top)
					counter_value <= `TFW_BOTTOM;
				else
					counter_value <= counter_value + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flags: a set in the same cycle as a clear wins
	// ----------------------------------------------------------------
	// Letting the set win means an event is never lost to a late clear.
	// Overflow follows the wrap in fast PWM, the bottom turn in phase-correct
	// PWM, and the roll from 0xFFFF in every other mode.
	// The capture flag marks top only in the modes where capture-top defines it.
	wire set_ovf = is_fast ? fast_wrap : (is_pc ? pc_bottom : (timer_tick & at_max));
	wire set_cap = timer_tick & top_from_cap & at_top & (~is_pc | count_up);

	always @(posedge clk) begin
		if (sys_rst) begin
			overflow_flag <= 1'b0;
			compare_a_flag <= 1'b0;
			compare_b_flag <= 1'b0;
			capture_flag <= 1'b0;
		end else begin
			overflow_flag <= set_ovf | (overflow_flag & ~flag_clr[`TFW_FLAG_OVF]);
			compare_a_flag <= match_a | (compare_a_flag & ~flag_clr[`TFW_FLAG_CMPA]);
			compare_b_flag <= match_b | (compare_b_flag & ~flag_clr[`TFW_FLAG_CMPB]);
			capture_flag <= set_cap | (capture_flag & ~flag_clr[`TFW_FLAG_CAPT]);
		end
	end

	// ----------------------------------------------------------------
	// Waveform state and pins
	// ----------------------------------------------------------------
	// The pin shows the next state at the same edge as the internal state.
	// The enable follows the direction bit only, whatever the action field holds.
	// A released pin is left to the board, which pulls it to a known level.
	always @(posedge clk) begin
		if (sys_rst) begin
			wave_a <= 1'b0;
			wave_b <= 1'b0;
			wave_pin_a_out <= 1'b0;
			wave_pin_b_out <= 1'b0;
			wave_pin_a_oe_n <= 1'b1;
			wave_pin_b_oe_n <= 1'b1;
		end else begin
			wave_a <= next_wave_a;
			wave_b <= next_wave_b;
			// A nonzero action hands the pin value to the waveform.
			wave_pin_a_out <= (output_a_action != 2'h0) ? next_wave_a : port_out_a;
			wave_pin_b_out <= (output_b_action != 2'h0) ? next_wave_b : port_out_b;
			wave_pin_a_oe_n <= ~ctrl[`TFW_CTRL_DIRA_BIT];
			wave_pin_b_oe_n <= ~ctrl[`TFW_CTRL_DIRB_BIT];
		end
	end

endmodule // tfw_wavegen

//--- rtl/tfw_wavegen_regs.vh
// Register map, field positions, reset values and mode codes of the timer wave generator.
`ifndef TFW_WAVEGEN_REGS_VH
`define TFW_WAVEGEN_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TFW_OFS_CTRL 5'h00
`define TFW_OFS_COUNT 5'h04
`define TFW_OFS_CMPA 5'h08
`define TFW_OFS_CMPB 5'h0C
`define TFW_OFS_CAPTOP 5'h10
`define TFW_OFS_FLAGS 5'h14
`define TFW_OFS_STATUS 5'h18

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define TFW_CTRL_MODE_LSB 0
`define TFW_CTRL_ACTA_LSB 4
`define TFW_CTRL_ACTB_LSB 6
`define TFW_CTRL_DIRA_BIT 8
`define TFW_CTRL_DIRB_BIT 9
`define TFW_CTRL_RST 10'h000
`define TFW_CNT_RST 16'h0000
`define TFW_CMP_RST 16'h0000
`define TFW_FLAG_OVF 0
`define TFW_FLAG_CMPA 1
`define TFW_FLAG_CMPB 2
`define TFW_FLAG_CAPT 3

// ----------------------------------------------------------------
// Modes and fixed tops
// ----------------------------------------------------------------
`define TFW_MODE_CLR_A 4'h4
`define TFW_MODE_CLR_I 4'hC
`define TFW_MODE_FP8 4'h5
`define TFW_MODE_FP9 4'h6
`define TFW_MODE_FP10 4'h7
`define TFW_MODE_FP_I 4'hE
`define TFW_MODE_FP_A 4'hF
`define TFW_MODE_PC8 4'h1
`define TFW_MODE_PC9 4'h2
`define TFW_MODE_PC10 4'h3
`define TFW_MODE_PC_I 4'hA
`define TFW_MODE_PC_A 4'hB
`define TFW_TOP8 16'h00FF
`define TFW_TOP9 16'h01FF
`define TFW_TOP10 16'h03FF
`define TFW_MAX 16'hFFFF
`define TFW_BOTTOM 16'h0000

`endif

//--- tb/tfw_pin_load.sv
// Board-side load of the two waveform pins, with pull-ups.
`timescale 1ns/1ns

module tfw_pin_load (
	// Driven side
	input wire a_out,
	input wire a_oe_n,
	input wire b_out,
	input wire b_oe_n,
	// Resolved levels
	output wire a_level,
	output wire b_level
);
	// A released pin floats to the pull-up level, so a stale value never shows.
	assign a_level = a_oe_n ? 1'b1 : a_out;
	assign b_level = b_oe_n ? 1'b1 : b_out;
endmodule // tfw_pin_load

//--- tb/tfw_wavegen_asserts.sv
// Checker of bus handshake, pin control and flag behaviour of the wave generator.
`timescale 1ns/1ns
`include "tfw_wavegen_regs.vh"

module tfw_wavegen_asserts (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Bus and tick
	input wire timer_tick,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// Pins and flags
	input wire port_out_a,
	input wire wave_pin_a_out,
	input wire wave_pin_a_oe_n,
	input wire wave_pin_b_oe_n,
	input wire overflow_flag,
	input wire compare_a_flag,
	input wire capture_flag
);
	// ----
	// Shadow state
	// ----
	reg [9:0] ctl_q;
	wire acc_w = avs_write && !avs_waitrequest;
	wire clr_ovf = acc_w && avs_address == `TFW_OFS_FLAGS && avs_byteenable[0] && avs_writedata[0];

	// Mirror control writes so pin checks know the action and direction bits.
	always @(posedge clk) begin
		if (sys_rst) begin
			ctl_q <= 10'h000;
		end else if (acc_w && avs_address == `TFW_OFS_CTRL) begin
			if (avs_byteenable[0]) ctl_q[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1]) ctl_q[9:8] <= avs_writedata[9:8];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// One low cycle of waitrequest, then high again.
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_wait_one_pulse: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
		else $error("waitrequest did not answer with one low cycle");
	a_idle_wait_high: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low while idle");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h18
		|-> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_oe_dir_a: assert property (1'b1 |=> wave_pin_a_oe_n == !$past(ctl_q[8]))
		else $error("pin A enable does not follow direction");
	a_oe_dir_b: assert property (1'b1 |=> wave_pin_b_oe_n == !$past(ctl_q[9]))
		else $error("pin B enable does not follow direction");
	a_port_pass_a: assert property (ctl_q[5:4] == 2'h0 |=> wave_pin_a_out == $past(port_out_a))
		else $error("pin A not under port control");
	a_ovf_clear: assert property (clr_ovf && !timer_tick |=> !overflow_flag)
		else $error("overflow flag not cleared");
	a_ovf_sticky: assert property (overflow_flag && !clr_ovf |=> overflow_flag)
		else $error("overflow flag dropped by itself");
	a_flag_on_tick: assert property ($rose(overflow_flag) || $rose(compare_a_flag) |-> $past(timer_tick))
		else $error("flag set without a timer tick");
	a_capt_on_tick: assert property ($rose(capture_flag) |-> $past(timer_tick))
		else $error("capture flag set without a timer tick");
endmodule // tfw_wavegen_asserts

bind tfw_wavegen tfw_wavegen_asserts tfw_wavegen_asserts_inst (
	.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .port_out_a(port_out_a), .wave_pin_a_out(wave_pin_a_out),
	.wave_pin_a_oe_n(wave_pin_a_oe_n), .wave_pin_b_oe_n(wave_pin_b_oe_n),
	.overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag), .capture_flag(capture_flag)
);

//--- tb/tfw_wavegen_tb.sv
// Self-checking bench of the timer wave generator.
`timescale 1ns/1ns
`include "tfw_wavegen_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tfw_wavegen_tb;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg timer_tick = 1'b0;
	reg [4:0] avs_address = 5'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h00000000;
	reg [3:0] avs_byteenable = 4'h0;
	reg port_out_a = 1'b0;
	reg port_out_b = 1'b0;
	reg [31:0] rdata;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, wave_pin_a_out, wave_pin_a_oe_n, wave_pin_b_out, wave_pin_b_oe_n;
	wire overflow_flag, compare_a_flag, compare_b_flag, capture_flag, a_level, b_level;
	integer num_errors = 0;
	integer checked = 0;
	integer cycles = 0;
	integer i;

	tfw_wavegen tfw_wavegen_inst (.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.port_out_a(port_out_a), .port_out_b(port_out_b), .wave_pin_a_out(wave_pin_a_out),
		.wave_pin_a_oe_n(wave_pin_a_oe_n), .wave_pin_b_out(wave_pin_b_out),
		.wave_pin_b_oe_n(wave_pin_b_oe_n), .overflow_flag(overflow_flag),
		.compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag),
		.capture_flag(capture_flag));
	tfw_pin_load tfw_pin_load_inst (.a_out(wave_pin_a_out), .a_oe_n(wave_pin_a_oe_n),
		.b_out(wave_pin_b_out), .b_oe_n(wave_pin_b_oe_n), .a_level(a_level), .b_level(b_level));

	// Free-running 10 MHz clock.
	initial begin
		forever #50 clk = ~clk;
	end

	// Cut a hang short after a generous cycle budget.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			complete_run;
		end
	end

	task complete_run;
		begin
			if (num_errors == 0 && checked > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask

	// ----
	// Bus and stimulus helpers
	// ----
	// One Avalon access, held until waitrequest is sampled low.
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_byteenable <= 4'hF;
			avs_write <= wr;
			avs_read <= !wr;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0) @(posedge clk);
			rdata = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd_chk(input logic [4:0] a, input logic [31:0] e);
		begin
			bus(1'b0, a, 32'h00000000);
			`CHK(rdata, e)
		end
	endtask

	task set_tick(input logic on);
		begin
			@(posedge clk);
			timer_tick <= on;
		end
	endtask

	// Count cycles until pin A changes level.
	task wait_chg(output integer n);
		reg t;
		begin
			t = a_level;
			n = 0;
			while (a_level === t && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
		end
	endtask

	// Reset values, a held counter and an unmapped read.
	task test_reset;
		begin
			rd_chk(`TFW_OFS_STATUS, 32'h00000004);
			rd_chk(`TFW_OFS_COUNT, 32'h00000000);
			rd_chk(5'h1C, 32'h00000000);
			rd_chk(`TFW_OFS_FLAGS, 32'h00000000);
		end
	endtask

	// Fixed-top modes mask compare bits above the top width.
	task test_mask;
		begin
			for (i = 0; i < 3; i++) begin
				wr(`TFW_OFS_CTRL, 32'h00000005 + i);
				wr(`TFW_OFS_CMPB, 32'h0000FFFF);
				rd_chk(`TFW_OFS_CMPB, (32'h00000100 << i) - 32'h00000001);
			end
		end
	endtask

	// Action 0 hands the pin to the port; direction gates the drive.
	task test_port;
		begin
			wr(`TFW_OFS_CTRL, 32'h00000300);
			port_out_a <= 1'b1;
			repeat (3) @(posedge clk);
			`CHK(a_level, 1'b1)
			port_out_a <= 1'b0;
			repeat (3) @(posedge clk);
			`CHK(a_level, 1'b0)
			wr(`TFW_OFS_CTRL, 32'h00000000);
			repeat (3) @(posedge clk);
			`CHK(wave_pin_a_oe_n, 1'b1)
		end
	endtask

	// Clear-on-compare toggle: half period 1+compare ticks, no overflow.
	task test_clr;
		integer n;
		begin
			wr(`TFW_OFS_CMPA, 32'h00000003);
			wr(`TFW_OFS_CTRL, 32'h00000114);
			set_tick(1'b1);
			wait_chg(n);
			wait_chg(n);
			`CHK(n, 4)
			wait_chg(n);
			`CHK(n, 4)
			set_tick(1'b0);
			`CHK(compare_a_flag, 1'b1)
			`CHK(overflow_flag, 1'b0)
			wr(`TFW_OFS_FLAGS, 32'h0000000F);
			rd_chk(`TFW_OFS_FLAGS, 32'h00000000);
		end
	endtask

	// Fast PWM with capture-top sets capture and overflow flags at top.
	task test_capt;
		begin
			wr(`TFW_OFS_CAPTOP, 32'h00000005);
			wr(`TFW_OFS_CTRL, 32'h0000000E);
			set_tick(1'b1);
			repeat (20) @(posedge clk);
			`CHK(capture_flag, 1'b1)
			`CHK(overflow_flag, 1'b1)
		end
	endtask

	// Duty of pin B and toggle of pin A with compare A as top 7.
	task pwm_case(input logic [3:0] m, input logic [1:0] act, input logic [31:0] c,
		input integer win, input integer expb);
		integer ha;
		integer hb;
		begin
			wr(`TFW_OFS_CMPA, 32'h00000007);
			wr(`TFW_OFS_CMPB, c);
			wr(`TFW_OFS_CTRL, {22'h000000, 2'h3, act, 2'h1, m});
			wr(`TFW_OFS_FLAGS, 32'h0000000F);
			repeat (40) @(posedge clk);
			ha = 0;
			hb = 0;
			repeat (win) begin
				@(posedge clk);
				ha = ha + a_level;
				hb = hb + b_level;
			end
			`CHK(hb, expb)
			`CHK(ha, win / 2)
			`CHK(overflow_flag, 1'b1)
			`CHK(compare_b_flag, 1'b1)
		end
	endtask

	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		test_reset;
		test_mask;
		test_port;
		test_clr;
		test_capt;
		pwm_case(4'hF, 2'h2, 32'h00000002, 32, 20);
		pwm_case(4'hF, 2'h3, 32'h00000002, 32, 12);
		pwm_case(4'hF, 2'h2, 32'h00000000, 32, 28);
		pwm_case(4'hF, 2'h2, 32'h00000007, 32, 0);
		pwm_case(4'hF, 2'h3, 32'h00000007, 32, 32);
		pwm_case(4'hB, 2'h2, 32'h00000002, 28, 8);
		complete_run;
	end
endmodule // tfw_wavegen_tb
